// ===== src/rtc_cal_map.svh
// register offsets, field positions, reset values and counts of the calibration block
// Overview of operation
// - crystal selected: correct at 16.384 kHz stage
// - normal mode: offset steps per 32 seconds
// - coarse mode: offset steps per 16 seconds
// - crystal offset is signed, -64 to +63
// - extended field slows by 122 ppm each
// - crystal corrections spread evenly over period
// - crystal correction exact each period
// - rc selected: correct at 64 Hz stage
// - rc range 00: 8,192 second period
// - rc range 01: 4,096 second period
// - rc range 10: 2,048 second period
// - rc range 11: 1,024 second period
// - rc offset is signed, -8,192 to +8,191
// - rc corrections spread evenly over period
`ifndef RTC_CAL_MAP_SVH
`define RTC_CAL_MAP_SVH
`define CAL_XT_OFS        12'h000
`define CAL_RC_OFS        12'h004
`define CAL_STAT_OFS      12'h008
`define CAL_SEC_OFS       12'h00C
`define CAL_XT_OFF_LSB    0
`define CAL_XT_COARSE_BIT 7
`define CAL_XT_EXT_LSB    8
`define CAL_OSC_SEL_BIT   16
`define CAL_RC_OFF_LSB    0
`define CAL_RC_RANGE_LSB  14
`define CAL_XT_RESET      32'h0000_0000
`define CAL_RC_RESET      32'h0000_0000
`define CAL_XT_STAGE_HZ   16384
`define CAL_RC_STAGE_HZ   64
`define CAL_XT_PERIOD_S   32
`define CAL_RC_PERIOD_S   8192
`define CAL_EXT_STEPS     64
`endif

// ===== src/rtc_cal_pkg.sv
// types of the calibration block
package rtc_cal_pkg;
	typedef struct packed {
		logic        oscillatorSelect;
		logic [1:0]  rcCalRange;
		logic [13:0] rcCalOffset;
		logic [1:0]  xtalExtendedSlowdown;
		logic        xtalCoarseMode;
		logic [6:0]  xtalCalOffset;
	} cal_cfg_t;
	typedef enum logic [0:0] {
		PH_EVEN  = 1'b0,
		PH_STAGE = 1'b1
	} phase_t;
endpackage : rtc_cal_pkg

// ===== src/rtc_digital_calibration.sv
// calibrated divider stage for crystal or rc oscillator, with apb registers
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
`include "rtc_cal_map.svh"
module rtc_digital_calibration #(
	parameter int ADDR_W = 12,
	parameter int ACC_W  = 19
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic              xtalTick,
	input  wire logic              rcTick,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	output logic                   stageTick,
	output logic                   secondTick,
	output rtc_cal_pkg::cal_cfg_t  calCfg
);
	import rtc_cal_pkg::*;

	// both periods hold 2^ACC_W stage pulses, so ACC_W stays at 19
	localparam logic [ADDR_W-1:0] A_XT   = ADDR_W'(`CAL_XT_OFS);
	localparam logic [ADDR_W-1:0] A_RC   = ADDR_W'(`CAL_RC_OFS);
	localparam logic [ADDR_W-1:0] A_STAT = ADDR_W'(`CAL_STAT_OFS);
	localparam logic [ADDR_W-1:0] A_SEC  = ADDR_W'(`CAL_SEC_OFS);
	localparam logic [13:0] XT_SEC_M1 = 14'(`CAL_XT_STAGE_HZ - 1);
	localparam logic [13:0] RC_SEC_M1 = 14'(`CAL_RC_STAGE_HZ - 1);

	// register state
	cal_cfg_t    cfg_q;
	cal_cfg_t    cfg_d;
	logic        pready_q;
	logic        pready_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic        pslverr_q;
	logic        pslverr_d;
	// divider state
	phase_t      phase_q;
	phase_t      phase_d;
	logic [ACC_W-1:0] acc_q;
	logic [ACC_W-1:0] acc_d;
	logic        addPend_q;
	logic        addPend_d;
	logic        stage_q;
	logic        stage_d;
	logic [13:0] subCnt_q;
	logic [13:0] subCnt_d;
	logic        sec_q;
	logic        sec_d;
	logic [15:0] secCnt_q;
	logic [15:0] secCnt_d;
	logic        selPrev_q;
	logic        selPrev_d;

	// combinational helpers
	logic        access;
	logic        commit;
	logic        srcTick;
	logic signed [19:0] xtEff;
	logic signed [19:0] rcEff;
	logic signed [19:0] eff;
	logic [19:0] mag;
	logic [ACC_W:0] sum;
	logic        carry;
	logic        stageEvt;

	assign access = psel & penable;
	assign commit = access & pready_q;

	// apb slave: one wait state, read data registered as pready rises, write at the edge that ends the pready cycle
	always_comb begin
		cfg_d     = cfg_q;
		pready_d  = access & ~pready_q;
		prdata_d  = prdata_q;
		pslverr_d = 1'b0;
		if (access && !pready_q) begin
			prdata_d  = 32'h0000_0000;
			if (paddr == A_XT) begin
				prdata_d[`CAL_XT_OFF_LSB +: 7]  = cfg_q.xtalCalOffset;
				prdata_d[`CAL_XT_COARSE_BIT]    = cfg_q.xtalCoarseMode;
				prdata_d[`CAL_XT_EXT_LSB +: 2]  = cfg_q.xtalExtendedSlowdown;
				prdata_d[`CAL_OSC_SEL_BIT]      = cfg_q.oscillatorSelect;
			end else if (paddr == A_RC) begin
				prdata_d[`CAL_RC_OFF_LSB +: 14]  = cfg_q.rcCalOffset;
				prdata_d[`CAL_RC_RANGE_LSB +: 2] = cfg_q.rcCalRange;
			end else if (paddr == A_STAT) begin
				prdata_d[ACC_W-1:0] = acc_q;
				prdata_d[24]        = addPend_q;
				prdata_d[25]        = phase_q;
				prdata_d[26]        = cfg_q.oscillatorSelect;
			end else if (paddr == A_SEC) begin
				prdata_d[15:0] = secCnt_q;
			end else begin
				pslverr_d = 1'b1;
			end
		end else if (commit) begin
			pslverr_d = pslverr_q;
		end
		if (commit && pwrite) begin
			if (paddr == A_XT) begin
				cfg_d.xtalCalOffset        = pwdata[`CAL_XT_OFF_LSB +: 7];
				cfg_d.xtalCoarseMode       = pwdata[`CAL_XT_COARSE_BIT];
				cfg_d.xtalExtendedSlowdown = pwdata[`CAL_XT_EXT_LSB +: 2];
				cfg_d.oscillatorSelect     = pwdata[`CAL_OSC_SEL_BIT];
			end else if (paddr == A_RC) begin
				cfg_d.rcCalOffset = pwdata[`CAL_RC_OFF_LSB +: 14];
				cfg_d.rcCalRange  = pwdata[`CAL_RC_RANGE_LSB +: 2];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cfg_q     <= cal_cfg_t'(`CAL_XT_RESET);
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			cfg_q     <= cfg_d;
			pready_q  <= pready_d;
			prdata_q  <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	// effective correction, counted in stage pulses per 2^19-pulse span
	always_comb begin
		// signed offset, scaled for the shorter coarse period
		xtEff = 20'(signed'(cfg_q.xtalCalOffset));
		if (cfg_q.xtalCoarseMode) begin
			xtEff = xtEff <<< 1;
		end
		// 64 steps of 1.907 ppm make 122 ppm of slowdown
		xtEff = xtEff - 20'(`CAL_EXT_STEPS) * 20'(cfg_q.xtalExtendedSlowdown);
		// range r shortens the period by 2^r
		rcEff = 20'(signed'(cfg_q.rcCalOffset)) <<< cfg_q.rcCalRange;
		// selected oscillator picks the stage and its correction
		eff = cfg_q.oscillatorSelect ? rcEff : xtEff;
		mag = eff[19] ? 20'(-eff) : 20'(eff);
	end

	assign srcTick  = cfg_q.oscillatorSelect ? rcTick : xtalTick;
	assign stageEvt = srcTick & (phase_q == PH_STAGE);
	// accumulator overflow spreads the corrections evenly
	assign sum      = {1'b0, acc_q} + (ACC_W+1)'(mag);
	assign carry    = sum[ACC_W];

	// stage divider with gating and added pulses
	always_comb begin
		phase_d   = phase_q;
		acc_d     = acc_q;
		addPend_d = addPend_q;
		stage_d   = 1'b0;
		if (srcTick) begin
			phase_d = (phase_q == PH_STAGE) ? PH_EVEN : PH_STAGE;
		end
		if (stageEvt) begin
			// span of 2^19 pulses returns the sum to its start value: exact per period
			acc_d   = sum[ACC_W-1:0];
			// with zero correction no carry ever occurs
			stage_d = ~(carry & eff[19]);
			if (carry && !eff[19]) begin
				addPend_d = 1'b1;
			end
		end else if (srcTick && addPend_q) begin
			// extra pulse from the oscillator rate between two stage pulses
			stage_d   = 1'b1;
			addPend_d = 1'b0;
		end
		if (cfg_q.oscillatorSelect != selPrev_q) begin
			acc_d     = '0;
			addPend_d = 1'b0;
			phase_d   = PH_EVEN;
		end
	end

	// seconds from the corrected stage
	always_comb begin
		subCnt_d  = subCnt_q;
		sec_d     = 1'b0;
		secCnt_d  = secCnt_q;
		selPrev_d = cfg_q.oscillatorSelect;
		if (stage_q) begin
			if (subCnt_q == (selPrev_q ? RC_SEC_M1 : XT_SEC_M1)) begin
				subCnt_d = '0;
				sec_d    = 1'b1;
				secCnt_d = secCnt_q + 16'h0001;
			end else begin
				subCnt_d = subCnt_q + 14'h0001;
			end
		end
		if (cfg_q.oscillatorSelect != selPrev_q) begin
			subCnt_d = '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			phase_q   <= PH_EVEN;
			acc_q     <= '0;
			addPend_q <= 1'b0;
			stage_q   <= 1'b0;
			subCnt_q  <= 14'h0000;
			sec_q     <= 1'b0;
			secCnt_q  <= 16'h0000;
			selPrev_q <= 1'b0;
		end else begin
			phase_q   <= phase_d;
			acc_q     <= acc_d;
			addPend_q <= addPend_d;
			stage_q   <= stage_d;
			subCnt_q  <= subCnt_d;
			sec_q     <= sec_d;
			secCnt_q  <= secCnt_d;
			selPrev_q <= selPrev_d;
		end
	end

	assign pready     = pready_q;
	assign prdata     = prdata_q;
	assign pslverr    = pslverr_q;
	assign stageTick  = stage_q;
	assign secondTick = sec_q;
	assign calCfg     = cfg_q;
endmodule : rtc_digital_calibration

// ===== tb/rtc_digital_calibration_monitor.sv
// concurrent checks on the calibration block ports
`timescale 1ns/1ps
module rtc_digital_calibration_monitor #(
	parameter int ADDR_W = 12
) (
	input wire logic              clk_sys,
	input wire logic              rst_n,
	input wire logic              xtalTick,
	input wire logic              rcTick,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic              pready,
	input wire logic [31:0]       prdata,
	input wire logic              pslverr,
	input wire logic              stageTick,
	input wire logic              secondTick,
	input wire rtc_cal_pkg::cal_cfg_t calCfg
);
	import rtc_cal_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	ready_wait_a: assert property (psel && !penable |-> ##1 !pready ##1 pready)
		else $error("pready not in second access cycle");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	err_decode_a: assert property (pready |-> pslverr == !(paddr inside {ADDR_W'(32'h0000_0000),
		ADDR_W'(32'h0000_0004), ADDR_W'(32'h0000_0008), ADDR_W'(32'h0000_000C)}))
		else $error("pslverr wrong for address");
	cfg_hold_a: assert property (!(pready && pwrite) |=> $stable(calCfg))
		else $error("configuration changed without a write");
	xt_write_a: assert property (pready && pwrite && paddr == '0 |=>
		{calCfg[26], calCfg[9:0]} == {$past(pwdata[16]), $past(pwdata[9:0])})
		else $error("crystal fields not taken from write");
	rc_write_a: assert property (pready && pwrite && paddr == ADDR_W'(32'h0000_0004) |=>
		calCfg[25:10] == $past(pwdata[15:0]))
		else $error("rc fields not taken from write");
	stage_cause_a: assert property (stageTick |->
		($past(calCfg.oscillatorSelect) ? $past(rcTick) : $past(xtalTick)))
		else $error("stage pulse without selected tick");
	stage_pulse_a: assert property (stageTick |=> !stageTick)
		else $error("stage pulse longer than one cycle");
endmodule : rtc_digital_calibration_monitor
bind rtc_digital_calibration rtc_digital_calibration_monitor #(.ADDR_W(ADDR_W)) mon (
	.clk_sys(clk_sys), .rst_n(rst_n), .xtalTick(xtalTick), .rcTick(rcTick), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .stageTick(stageTick), .secondTick(secondTick),
	.calCfg(calCfg));

// ===== tb/tb.sv
// self-checking bench of the calibration block
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
	$display("Error %s expected %0h seen %0h", n, e, g); end end
module tb;
	import rtc_cal_pkg::*;
	typedef struct {logic [31:0] xt, rc; int n, lo, hi;} row_t;
	logic        clk_sys = 0, rst_n = 0, xtalTick = 0, rcTick = 0, er;
	logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, stageTick;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	cal_cfg_t    calCfg;
	int          fail_count = 0, cmp_count = 0, cyc = 0, stg = 0, base;
	// first rows run with calibration cleared
	// offsets stay inside the host bands
	row_t rows[9] = '{'{0, 0, 200, 100, 100}, '{32'h0001_0000, 0, 200, 100, 100},
		'{32'h0001_0000, 32'h0000_E000, 400, 174, 176}, '{32'h0001_0000, 32'h0000_DFFF, 400, 224, 226},
		'{32'h0001_0000, 32'h0000_A000, 400, 186, 189}, '{32'h0001_0000, 32'h0000_6000, 400, 192, 195},
		'{32'h0001_0000, 32'h0000_2000, 400, 195, 198}, '{32'h0000_03C0, 0, 8192, 4092, 4095},
		'{32'h0000_00BF, 0, 8192, 4095, 4098}};
	rtc_digital_calibration uut (.clk_sys(clk_sys), .rst_n(rst_n), .xtalTick(xtalTick),
		.rcTick(rcTick), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.stageTick(stageTick), .secondTick(), .calCfg(calCfg));
	initial forever #4 clk_sys = !clk_sys;
	task automatic end_sim;
		$display("checks %0d errors %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_sim
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (stageTick === 1'b1) stg <= stg + 1;
		if (cyc == 90000) begin
			fail_count++;
			end_sim();
		end
	end
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic ticks(input int n, input logic rc);
		for (int i = 0; i < 2 * n; i++) begin
			@(posedge clk_sys);
			xtalTick <= (i % 2 == 0) ? !rc : rc;
			rcTick <= (i % 2 == 0) ? rc : !rc;
			@(posedge clk_sys);
			xtalTick <= 0;
			rcTick <= 0;
		end
	endtask : ticks
	initial begin
		repeat (12) @(posedge clk_sys);
		`CHK("calCfg", 27'h000_0000, calCfg)
		rst_n <= 1;
		foreach (rows[i]) begin
			apb(12'h004, 1, rows[i].rc);
			apb(12'h000, 1, rows[i].xt);
			apb(12'h000, 0, 0);
			`CHK("calCfg", {rows[i].xt[16], rows[i].rc[15:0], rows[i].xt[9:0]}, calCfg)
			`CHK("xtRead", {rows[i].xt[16], rows[i].xt[9:0]}, {rd[16], rd[9:0]})
			base = stg;
			ticks(rows[i].n, rows[i].xt[16]);
			repeat (3) @(posedge clk_sys);
			`CHK("stageCount", 1'b1, stg - base inside {[rows[i].lo:rows[i].hi]})
		end
		apb(12'h100, 0, 0);
		`CHK("unmappedErr", 1'b1, er)
		`CHK("unmappedData", 32'h0000_0000, rd)
		apb(12'h100, 1, 32'h0000_0001);
		apb(12'h008, 1, 32'h0000_0001);
		`CHK("statErr", 1'b0, er)
		`CHK("calCfg", 27'h000_00BF, calCfg)
		rst_n <= 0;
		repeat (2) @(posedge clk_sys);
		`CHK("resetCfg", 27'h000_0000, calCfg)
		end_sim();
	end
endmodule : tb
